// ==== verilog/adc_seq_pkg.sv ====
`default_nettype none
package adc_seq_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_CTRL2 = 8'h08;
    localparam logic [7:0] OFF_RESH = 8'h0c;
    localparam logic [7:0] OFF_RESL = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_PORT = 8'h18;

    // Field positions
    localparam int CTRL0_EN = 0;
    localparam int CTRL0_GO = 1;
    localparam int CTRL0_CHAN_LSB = 2;
    localparam int CTRL2_CLK_LSB = 0;
    localparam int CTRL2_ACQ_LSB = 3;
    localparam int CTRL2_JUST = 7;
    localparam int STATUS_DONE = 0;

    // Values after reset
    localparam logic [2:0] ACQ_RST = 3'h0;
    localparam logic [2:0] CLK_RST = 3'h0;
    localparam logic [3:0] CHAN_RST = 4'h0;
    localparam logic [3:0] PCFG_RST_ANALOG = 4'h0;
    localparam logic [3:0] PCFG_RST_DIGITAL = 4'h7;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // Timing, in nanoseconds, conversion bit periods and clock cycles, and channel count
    localparam int CLK_PERIOD_NS = 20;
    localparam int INSTR_CYCLE_NS = 80;
    localparam int HOLDOFF_CYCLES =
        (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CONV_LAST_IDX = 4'ha;
    localparam logic [4:0] WAIT_TADS = 5'h02;
    localparam int NUM_CHAN = 13;

    typedef enum {
        ST_OFF, ST_DISCHARGE, ST_SAMPLE, ST_ACQ, ST_HOLDOFF, ST_CONV, ST_WAIT
    } seq_state_t;

    typedef struct packed {
        logic justify;
        logic [2:0] acq;
        logic [2:0] clk;
    } conv_cfg_t;

    typedef struct packed {
        logic hold_connect;
        logic discharge;
        logic [3:0] chan;
        logic [9:0] dac_code;
    } analog_ctl_t;

endpackage : adc_seq_pkg
`default_nettype wire

// ==== verilog/adc_acquisition_sequencer.sv ====
// Operation
// RL1 - Software waits acquisition time after channel change
// RL2 - Hold capacitor disconnects when conversion begins
// RL3 - Nonzero acquisition field delays start automatically
// RL4 - Field 000 starts conversion without delay
// RL5 - Acquisition field resets to manual
// RL6 - Completion clears go, sets flag, resamples
// RL7 - Go stays set through acquisition and conversion
// RL8 - Conversion takes exactly eleven bit periods
// RL9 - Clock field picks divider or RC
// RL10 - Software picks RC below 1 MHz
// RL11 - Only RC clock runs during sleep
// RL12 - Manual start held off one instruction
// RL13 - Software keeps clock source during conversion
// RL14 - Software clears idle select before sleep
// RL15 - Analog pins read as zero
// RL16 - Selected pin converted regardless of direction
// RL17 - Fuse selects port configuration reset value
// RL18 - Clearing go aborts running conversion
// RL19 - Abort leaves result pair untouched
// RL20 - Two bit periods wait, then resample
// RL21 - Software never sets go with enable
// RL22 - Discharge precedes every sampling phase
// RL23 - Acquisition field encodes delay in periods
// RL24 - Justify bit selects result alignment
// RL25 - Reset disables converter, aborts conversion
// RL26 - Configuration resets 0000 or 0111 by fuse
// RL27 - Go ignored while converter disabled
// RL28 - RC clock events synchronised without loss
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none
module adc_acquisition_sequencer
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Pins and analog front end
    input wire logic internal_rc_clock,
    input wire logic sleep_mode,
    input wire logic portb_analog_reset_fuse,
    input wire logic comp_high,
    input wire logic [12:0] pin_level,
    output analog_ctl_t ana
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Acquisition field to bit periods
    function automatic logic [4:0] acq_tads(input logic [2:0] sel);
        logic [4:0] t;
        t = 5'h00;
        unique case (sel)
            3'h0: t = 5'h00;
            3'h1: t = 5'h02;
            3'h2: t = 5'h04;
            3'h3: t = 5'h06;
            3'h4: t = 5'h08;
            3'h5: t = 5'h0c;
            3'h6: t = 5'h10;
            3'h7: t = 5'h14;
        endcase
        return t;
    endfunction : acq_tads

    // Clock field to oscillator periods per bit period
    function automatic logic [6:0] osc_div(input logic [2:0] sel);
        logic [6:0] d;
        d = 7'h02;
        unique case (sel)
            3'h0: d = 7'h02;
            3'h4: d = 7'h04;
            3'h1: d = 7'h08;
            3'h5: d = 7'h10;
            3'h2: d = 7'h20;
            3'h6: d = 7'h40;
            default: d = 7'h02;
        endcase
        return d;
    endfunction : osc_div

    // Port configuration to analog pin mask
    function automatic logic [12:0] analog_mask(input logic [3:0] pcfg);
        logic [12:0] m;
        m = 13'h1fff;
        if (pcfg > 4'h2)
            m = 13'h1fff >> (pcfg - 4'h2);
        return m;
    endfunction : analog_mask

    ////////////////////////////////////////////////////////////////////
    // Synchronisers

    logic rc_s1, rc_s2, rc_s3;
    logic slp_s1, slp_s2;
    logic fuse_s1, fuse_s2;
    logic [12:0] pin_s1, pin_s2;

    // Two flops on the RC clock, sleep, fuse and pin inputs, third for RC edge
    always_ff @(posedge ref_clk)
    begin
        {rc_s3, rc_s2, rc_s1} <= {rc_s2, rc_s1, internal_rc_clock}; // RL28
        {slp_s2, slp_s1} <= {slp_s1, sleep_mode};
        {fuse_s2, fuse_s1} <= {fuse_s1, portb_analog_reset_fuse};
        {pin_s2, pin_s1} <= {pin_s1, pin_level};
    end

    ////////////////////////////////////////////////////////////////////
    // Registers and bus

    logic enable, go, done_flag;
    logic [3:0] chan_sel, pcfg;
    conv_cfg_t cfg;
    logic [15:0] result_pair;
    logic wr_pend;
    logic [7:0] wr_addr;
    seq_state_t state, next_state;
    logic [4:0] cnt;
    logic [3:0] idx;
    logic [9:0] sar;
    logic [6:0] div_cnt;

    // Bus decode
    wire addr_phase = hsel && htrans[1] && hready;
    wire wr_ctrl0 = wr_pend && wr_addr == OFF_CTRL0;
    wire wr_ctrl1 = wr_pend && wr_addr == OFF_CTRL1;
    wire wr_ctrl2 = wr_pend && wr_addr == OFF_CTRL2;
    wire wr_resh = wr_pend && wr_addr == OFF_RESH;
    wire wr_resl = wr_pend && wr_addr == OFF_RESL;
    wire wr_stat = wr_pend && wr_addr == OFF_STATUS;
    wire [12:0] port_value = pin_s2 & ~analog_mask(pcfg); // RL15

    // Read mux
    wire [31:0] rd_mux =
        (haddr == OFF_CTRL0) ? {26'h0, chan_sel, go, enable} :
        (haddr == OFF_CTRL1) ? {28'h0, pcfg} :
        (haddr == OFF_CTRL2) ? {24'h0, cfg.justify, 1'b0, cfg.acq,
                                cfg.clk} :
        (haddr == OFF_RESH) ? {24'h0, result_pair[15:8]} :
        (haddr == OFF_RESL) ? {24'h0, result_pair[7:0]} :
        (haddr == OFF_STATUS) ? {31'h0, done_flag} :
        (haddr == OFF_PORT) ? {19'h0, port_value} : 32'h0;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture, read data ready for data phase
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0;
        end
        else
        begin
            wr_pend <= addr_phase && hwrite;
            wr_addr <= haddr;
            if (addr_phase && !hwrite)
                hrdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Conversion clock

    wire rc_sel = cfg.clk[1:0] == 2'b11;
    wire [6:0] div_last = osc_div(cfg.clk) - 7'h01;
    wire osc_tick = !slp_s2 && div_cnt >= div_last;
    wire rc_tick = rc_s2 && !rc_s3;
    wire tad_tick = rc_sel ? rc_tick : osc_tick; // RL9 RL11

    // Divider halts in sleep, realigns on each phase change
    always_ff @(posedge ref_clk)
    begin
        if (srst || osc_tick || state != next_state)
            div_cnt <= 7'h00;
        else if (!slp_s2)
            div_cnt <= div_cnt + 7'h01;
    end

    ////////////////////////////////////////////////////////////////////
    // Control flags

    wire busy = state == ST_ACQ || state == ST_HOLDOFF || state == ST_CONV;
    wire sw_go_set = wr_ctrl0 && hwdata[CTRL0_GO] && enable; // RL27 RL21
    wire sw_go_clr = wr_ctrl0 &&
        (!hwdata[CTRL0_GO] || !hwdata[CTRL0_EN]);
    wire done_evt = state == ST_CONV && go && tad_tick &&
        idx == CONV_LAST_IDX;
    wire [3:0] bitpos = 4'ha - idx;
    wire [9:0] trial = 10'h001 << bitpos;
    // Comparator follows our registered trial code; a two-flop delay
    // would leave it stale at the fastest bit period
    wire [9:0] sar_next = (comp_high ? sar : sar & ~trial) | (trial >> 1);
    wire [15:0] formatted = cfg.justify ? {6'h00, sar_next} : // RL24
        {sar_next, 6'h00};

    // Control registers, go set wins over clear
    always_ff @(posedge ref_clk)
    begin
        if (srst) // RL25
        begin
            enable <= 1'b0;
            go <= 1'b0;
            chan_sel <= CHAN_RST;
            cfg <= {1'b0, ACQ_RST, CLK_RST}; // RL5
            pcfg <= fuse_s2 ? PCFG_RST_ANALOG : PCFG_RST_DIGITAL; // RL17 RL26
        end
        else
        begin
            if (wr_ctrl0)
            begin
                enable <= hwdata[CTRL0_EN];
                chan_sel <= hwdata[CTRL0_CHAN_LSB +: 4];
            end
            if (sw_go_set)
                go <= 1'b1; // RL7
            else if (done_evt || sw_go_clr) // RL6 RL18
                go <= 1'b0;
            if (wr_ctrl1)
                pcfg <= hwdata[3:0];
            if (wr_ctrl2)
                cfg <= {hwdata[CTRL2_JUST], hwdata[CTRL2_ACQ_LSB +: 3],
                        hwdata[CTRL2_CLK_LSB +: 3]};
        end
    end

    // Done flag and result pair; hardware wins over software
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            done_flag <= 1'b0;
            result_pair <= RESULT_RST;
        end
        else
        begin
            if (done_evt)
                done_flag <= 1'b1; // RL6
            else if (wr_stat && hwdata[STATUS_DONE])
                done_flag <= 1'b0;
            if (done_evt)
                result_pair <= formatted;
            else if (wr_resh) // RL19
                result_pair[15:8] <= hwdata[7:0];
            else if (wr_resl)
                result_pair[7:0] <= hwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer

    // Next phase
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_OFF: if (enable) next_state = ST_DISCHARGE;
            ST_DISCHARGE: if (tad_tick) next_state = ST_SAMPLE; // RL22
            ST_SAMPLE:
                if (go)
                    next_state = (cfg.acq == 3'h0) ? ST_HOLDOFF // RL4 RL12
                        : ST_ACQ; // RL3
            ST_ACQ:
                if (!go) next_state = ST_WAIT;
                else if (tad_tick && cnt == 5'h01) next_state = ST_CONV;
            ST_HOLDOFF:
                if (!go) next_state = ST_WAIT;
                else if (cnt == 5'h00) next_state = ST_CONV;
            ST_CONV:
                if (!go || done_evt) next_state = ST_WAIT; // RL18
            ST_WAIT:
                if (tad_tick && cnt == 5'h01)
                    next_state = ST_DISCHARGE; // RL20
        endcase
        if (!enable)
            next_state = ST_OFF; // RL27
    end

    // Phase counters and successive approximation
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state <= ST_OFF;
            cnt <= 5'h00;
            idx <= 4'h0;
            sar <= 10'h200;
        end
        else
        begin
            state <= next_state;
            if (state != next_state)
                unique case (next_state)
                    ST_ACQ: cnt <= acq_tads(cfg.acq); // RL23
                    ST_HOLDOFF: cnt <= 5'(HOLDOFF_CYCLES - 1);
                    ST_WAIT: cnt <= WAIT_TADS;
                    default: cnt <= 5'h00;
                endcase
            else if (state == ST_HOLDOFF || tad_tick)
                cnt <= cnt - 5'h01;
            if (next_state == ST_CONV && state != ST_CONV)
            begin
                idx <= 4'h0;
                sar <= 10'h200;
            end
            else if (state == ST_CONV && tad_tick) // RL8
            begin
                idx <= idx + 4'h1;
                if (idx != 4'h0)
                    sar <= sar_next;
            end
        end
    end

    // Analog controls follow the phase; channel ignores pin direction
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            ana <= '0;
        else
        begin
            ana.hold_connect <= next_state == ST_SAMPLE ||
                next_state == ST_ACQ; // RL2
            ana.discharge <= next_state == ST_DISCHARGE; // RL22
            ana.chan <= chan_sel; // RL16
            ana.dac_code <= (state == ST_CONV && tad_tick && idx != 4'h0)
                ? sar_next : sar;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    logic [3:0] conv_ticks;

    // Bit periods seen in the current conversion
    always_ff @(posedge ref_clk)
    begin
        if (srst || state != ST_CONV)
            conv_ticks <= 4'h0;
        else if (tad_tick)
            conv_ticks <= conv_ticks + 4'h1;
    end

    hold_open_a: assert property ( // RL2
        @(posedge ref_clk) disable iff (srst)
        (state == ST_CONV && $past(state) == ST_CONV) |-> !ana.hold_connect)
        else $error("hold capacitor connected during conversion");

    go_busy_a: assert property ( // RL7
        @(posedge ref_clk) disable iff (srst)
        (busy && $past(busy) && $past(go) && !$past(sw_go_clr)) |-> go)
        else $error("go dropped while busy");

    manual_start_a: assert property ( // RL12
        @(posedge ref_clk) disable iff (srst)
        (state == ST_SAMPLE && go && enable && cfg.acq == 3'h0)
        |=> state == ST_HOLDOFF)
        else $error("manual start skipped holdoff");

    acq_reset_a: assert property ( // RL5
        @(posedge ref_clk) disable iff (srst)
        $past(srst) |-> (cfg.acq == 3'h0 && !enable && !go))
        else $error("control fields not reset");

    done_seq_a: assert property ( // RL6
        @(posedge ref_clk) disable iff (srst)
        done_evt |=> (done_flag && state != ST_CONV) ##[1:400]
        state == ST_SAMPLE || state == ST_OFF || !enable)
        else $error("completion sequence wrong");

    conv_len_a: assert property ( // RL8
        @(posedge ref_clk) disable iff (srst)
        done_evt |-> conv_ticks == 4'ha)
        else $error("conversion not eleven bit periods");

    port_zero_a: assert property ( // RL15
        @(posedge ref_clk) disable iff (srst)
        (addr_phase && !hwrite && haddr == OFF_PORT && pcfg == 4'h0)
        |=> hrdata == 32'h0)
        else $error("analog pin reads nonzero");

    abort_keep_a: assert property ( // RL19
        @(posedge ref_clk) disable iff (srst)
        (state == ST_CONV && !go && !wr_resh && !wr_resl)
        |=> $stable(result_pair))
        else $error("abort changed result");

    sleep_stop_a: assert property ( // RL11
        @(posedge ref_clk) disable iff (srst)
        (slp_s2 && !rc_sel && state == ST_CONV) |=> $stable(idx))
        else $error("divider ticked in sleep");

    discharge_first_a: assert property ( // RL22
        @(posedge ref_clk) disable iff (srst)
        (state == ST_SAMPLE && $past(state) != ST_SAMPLE)
        |-> $past(state) == ST_DISCHARGE)
        else $error("sampling without discharge");

    disabled_idle_a: assert property ( // RL27
        @(posedge ref_clk) disable iff (srst)
        !enable |=> state == ST_OFF)
        else $error("sequencer active while disabled");

endmodule : adc_acquisition_sequencer
`default_nettype wire

// ==== test/adc_front_model.sv ====
`default_nettype none
module adc_front_model
    import adc_seq_pkg::*;
(
    // Sampler control from the sequencer
    input wire analog_ctl_t ana,
    // Comparator answer
    output logic comp_high
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [9:0] chan_level;

    ////////////////////////////////////////////////////////////////////
    // Fixed level per channel, whatever the pin direction
    assign chan_level = 10'h0a3 + 10'(ana.chan) * 10'h045;
    assign comp_high = (chan_level >= ana.dac_code);
endmodule : adc_front_model
`default_nettype wire

// ==== test/tb_adc_acquisition_sequencer.sv ====
`default_nettype none
module tb_adc_acquisition_sequencer
    import adc_seq_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic rc_clk = 1'b0;
    logic sleep_mode = 1'b0;
    logic fuse = 1'b1;
    logic [12:0] pin_level = 13'h1fff;
    wire hready;
    wire hresp;
    wire [31:0] hrdata;
    wire analog_ctl_t ana;
    wire comp_high;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    int rc_div = 0;
    int dis_cnt = 0;
    int low_cnt = 0;
    int hi_cnt = 0;

    adc_acquisition_sequencer dut (
        .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .internal_rc_clock(rc_clk),
        .sleep_mode(sleep_mode), .portb_analog_reset_fuse(fuse),
        .comp_high(comp_high), .pin_level(pin_level), .ana(ana)
    );

    adc_front_model front (.ana(ana), .comp_high(comp_high));

    ////////////////////////////////////////////////////////////////////
    // Clock
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end

    // RC oscillator, timeout and phase counters
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        rc_div <= (rc_div == 4) ? 0 : rc_div + 1;
        if (rc_div == 4)
            rc_clk <= ~rc_clk;
        dis_cnt <= dis_cnt + int'(ana.discharge === 1'b1);
        low_cnt <= low_cnt + int'(ana.hold_connect === 1'b0
            && ana.discharge === 1'b0);
        hi_cnt <= hi_cnt + int'(ana.hold_connect === 1'b1);
        if (cycles == 60000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        check(q, e);
    endtask : rd_chk

    task automatic wait_done(input int lim);
        logic [31:0] q;
        int n;
        n = 0;
        do bus(OFF_CTRL0, 1'b0, 32'h0, q);
        while (q[CTRL0_GO] === 1'b1 && n++ < lim);
        check(q[CTRL0_GO], 1'b0);
    endtask : wait_done

    task automatic wait_hold(input logic lvl, input int lim);
        int n;
        n = 0;
        do @(posedge ref_clk);
        while (ana.hold_connect !== lvl && n++ < lim);
        check(ana.hold_connect, lvl);
    endtask : wait_hold

    ////////////////////////////////////////////////////////////////////
    // One full conversion with a given clock, acquisition and channel
    task automatic run_conv(input logic [2:0] clk, input logic [2:0] acq,
                            input int n, input int t);
        logic [9:0] r;
        logic just;
        int d0;
        int l0;
        int h;
        int tol;
        r = 10'h0a3 + 10'(acq) * 10'h045;
        just = acq[0];
        tol = (clk[1:0] == 2'h3) ? n : 3;
        sleep_mode <= (clk[1:0] == 2'h3);
        wr(OFF_CTRL2, {24'h0, just, 1'b0, acq, clk});
        wr(OFF_CTRL0, {26'h0, 1'b0, acq, 2'h1});
        wait_hold(1'b1, 3000);
        wr(OFF_CTRL0, {26'h0, 1'b0, acq, 2'h3});
        h = hi_cnt;
        wait_hold(1'b0, 3000);
        h = hi_cnt - h;
        check(h >= t * n - tol && h <= t * n + HOLDOFF_CYCLES + tol, 1);
        d0 = dis_cnt;
        l0 = low_cnt;
        wait_done(3000);
        rd_chk(OFF_STATUS, 32'h1);
        rd_chk(OFF_RESH, just ? 32'(r[9:8]) : 32'(r[9:2]));
        rd_chk(OFF_RESL, just ? 32'(r[7:0]) : 32'({r[1:0], 6'h0}));
        wr(OFF_STATUS, 32'h1);
        wait_hold(1'b1, 3000);
        check(dis_cnt - d0, n);
        check(low_cnt - l0, 13 * n + (t == 0 ? HOLDOFF_CYCLES : 0));
    endtask : run_conv

    // Abort in mid-conversion keeps the software-written result
    task automatic abort_conv();
        sleep_mode <= 1'b0;
        wr(OFF_CTRL2, 32'h0e);
        wr(OFF_RESH, 32'h5a);
        wr(OFF_RESL, 32'hc3);
        wr(OFF_CTRL0, 32'h3);
        rd_chk(OFF_CTRL0, 32'h3);
        check(ana.hold_connect, 1'b1);
        repeat (300) @(posedge ref_clk);
        check(ana.hold_connect, 1'b0);
        rd_chk(OFF_CTRL0, 32'h3);
        wr(OFF_CTRL0, 32'h1);
        rd_chk(OFF_CTRL0, 32'h1);
        wait_hold(1'b1, 1000);
        rd_chk(OFF_RESH, 32'h5a);
        rd_chk(OFF_RESL, 32'hc3);
        rd_chk(OFF_STATUS, 32'h0);
    endtask : abort_conv

    // Divided clock halts in sleep
    task automatic sleep_stall();
        sleep_mode <= 1'b1;
        wr(OFF_CTRL2, 32'h0);
        wr(OFF_CTRL0, 32'h3);
        repeat (200) @(posedge ref_clk);
        rd_chk(OFF_CTRL0, 32'h3);
        sleep_mode <= 1'b0;
        wait_done(200);
        wr(OFF_STATUS, 32'h1);
    endtask : sleep_stall

    // Reset in mid-conversion with the fuse low
    task automatic reset_mid();
        wr(OFF_CTRL2, 32'h06);
        wr(OFF_CTRL0, 32'h3);
        repeat (100) @(posedge ref_clk);
        srst <= 1'b1;
        fuse <= 1'b0;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        rd_chk(OFF_CTRL0, 32'h0);
        rd_chk(OFF_CTRL1, 32'h7);
        rd_chk(OFF_CTRL2, 32'h0);
    endtask : reset_mid

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [2:0] clk_tab [8];
        int n_tab [8];
        int t_tab [8];
        clk_tab = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
        n_tab = '{2, 4, 8, 16, 32, 64, 10, 10};
        t_tab = '{0, 2, 4, 6, 8, 12, 16, 20};
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        rd_chk(OFF_CTRL0, 32'h0);
        rd_chk(OFF_CTRL2, 32'h0);
        rd_chk(OFF_CTRL1, 32'h0);
        rd_chk(OFF_STATUS, 32'h0);
        rd_chk(OFF_PORT, 32'h0);
        wr(OFF_CTRL1, 32'h7);
        rd_chk(OFF_PORT, 32'h1f00);
        wr(OFF_CTRL1, 32'h0);
        wr(OFF_CTRL0, 32'h2);
        rd_chk(OFF_CTRL0, 32'h0);
        check(ana.hold_connect, 1'b0);
        for (int i = 0; i < 8; i++)
            run_conv(clk_tab[i], 3'(i), n_tab[i], t_tab[i]);
        abort_conv();
        sleep_stall();
        reset_mid();
        tally_and_finish();
    end
endmodule : tb_adc_acquisition_sequencer
`default_nettype wire
